/* File: bpt_pkg.sv */
`default_nettype none
package bpt_pkg;
	localparam int CNT_W = 16;
	localparam int MODE_W = 7;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [4:0] OFS_COMPARE_A = 5'h00;
	localparam logic [4:0] OFS_COMPARE_B = 5'h04;
	localparam logic [4:0] OFS_CONTROL   = 5'h0C;
	localparam logic [4:0] OFS_STATUS    = 5'h10;
	localparam logic [4:0] OFS_ALT_TRIG  = 5'h14;

	// ----------------------------------------------------------------
	// control and status fields
	// ----------------------------------------------------------------
	localparam int CTL_MODE_LSB   = 0;
	localparam int CTL_EDGE_POLARITY_BIT  = 7;
	localparam int CTL_FORCE_A    = 8;
	localparam int CTL_FORCE_B    = 9;
	localparam int STS_FLAG_BIT   = 0;
	localparam int MODE_FLAG_SEL  = 1;

	// ----------------------------------------------------------------
	// mode encodings
	// ----------------------------------------------------------------
	localparam logic [6:0] MODE_BUF_MASK = 7'h7D;
	localparam logic [6:0] MODE_BUF_CODE = 7'h60;
	localparam logic [6:0] MODE_SHIFT    = 7'h26;
	localparam logic [6:0] MODE_RESET    = 7'h00;
	localparam logic [15:0] CMP_RESET    = 16'h0000;
	localparam logic [15:0] BOUNDARY_PRE = 16'h0002;
	localparam logic [15:0] BOUNDARY_NOW = 16'h0001;
	localparam logic [15:0] ZERO_VALUE   = 16'h0000;

	typedef enum logic [1:0] {
		BPT_IDLE  = 2'b00,
		BPT_BUF   = 2'b01,
		BPT_SHIFT = 2'b10
	} bpt_mode_t;

	typedef struct packed {
		logic        wr_a;
		logic        wr_b;
		logic        wr_alt;
		logic        wr_ctrl;
		logic        clr_flag;
		logic        force_a_match;
		logic        force_b_match;
		logic [15:0] data;
	} bpt_wr_t;

	typedef struct packed {
		logic rise;
		logic fall;
	} bpt_edge_t;
endpackage
`default_nettype wire

/* File: bpt_match.sv */
`default_nettype none
module bpt_match
	import bpt_pkg::*;
#(
	parameter int W = CNT_W
) (
	input  wire logic         i_ref_clk,
	input  wire logic         i_rst_b,
	input  wire logic         i_count_en,
	input  wire logic [W-1:0] i_counter_bus,
	input  wire logic [W-1:0] i_value,
	output bpt_edge_t         o_edge
);
	logic match;
	logic next_match;

	// ----------------------------------------------------------------
	// comparator with edge detection
	// ----------------------------------------------------------------
	always_comb begin
		next_match = match;
		if (i_count_en) begin
			next_match = (i_counter_bus == i_value);
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			match <= 1'b0;
		end else begin
			match <= next_match;
		end
	end

	assign o_edge.rise = next_match & ~match;
	assign o_edge.fall = ~next_match & match;
endmodule
`default_nettype wire

/* File: bpt_regs.sv */
`default_nettype none
module bpt_regs
	import bpt_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	input  wire logic [4:0]  i_reg_addr,
	input  wire logic [31:0] i_reg_wdata,
	input  wire logic [15:0] i_rd_a,
	input  wire logic [15:0] i_rd_b,
	input  wire logic [15:0] i_rd_alt,
	input  wire logic [9:0]  i_rd_ctrl,
	input  wire logic        i_rd_flag,
	output bpt_wr_t          o_wr,
	output logic [31:0]      o_reg_rdata
);
	logic [31:0] next_rdata;

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	always_comb begin
		o_wr = '0;
		o_wr.data = i_reg_wdata[15:0];
		if (i_reg_wr) begin
			if (i_reg_addr == OFS_COMPARE_A) begin
				o_wr.wr_a = 1'b1;
			end else if (i_reg_addr == OFS_COMPARE_B) begin
				o_wr.wr_b = 1'b1;
			end else if (i_reg_addr == OFS_ALT_TRIG) begin
				o_wr.wr_alt = 1'b1;
			end else if (i_reg_addr == OFS_CONTROL) begin
				o_wr.wr_ctrl = 1'b1;
				o_wr.force_a_match = i_reg_wdata[CTL_FORCE_A];
				o_wr.force_b_match = i_reg_wdata[CTL_FORCE_B];
			end else if (i_reg_addr == OFS_STATUS) begin
				o_wr.clr_flag = i_reg_wdata[STS_FLAG_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb begin
		next_rdata = o_reg_rdata;
		if (i_reg_rd) begin
			if (i_reg_addr == OFS_COMPARE_A) begin
				next_rdata = {16'h0000, i_rd_a};
			end else if (i_reg_addr == OFS_COMPARE_B) begin
				next_rdata = {16'h0000, i_rd_b};
			end else if (i_reg_addr == OFS_ALT_TRIG) begin
				next_rdata = {16'h0000, i_rd_alt};
			end else if (i_reg_addr == OFS_CONTROL) begin
				next_rdata = {22'h000000, i_rd_ctrl};
			end else if (i_reg_addr == OFS_STATUS) begin
				next_rdata = {31'h00000000, i_rd_flag};
			end else begin
				next_rdata = 32'h00000000;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			o_reg_rdata <= 32'h00000000;
		end else begin
			o_reg_rdata <= next_rdata;
		end
	end
endmodule
`default_nettype wire

/* File: bpt_channel.sv */
`default_nettype none
module bpt_channel
	import bpt_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	input  wire logic [4:0]  i_reg_addr,
	input  wire logic [31:0] i_reg_wdata,
	output logic [31:0]      o_reg_rdata,
	input  wire logic [15:0] i_counter_bus,
	input  wire logic        i_count_en,
	input  wire logic        i_output_update_disable_bit,
	output logic             o_pwm,
	output logic             o_flag,
	output logic [1:0]       o_mode_state
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	bpt_wr_t     wr;
	bpt_edge_t   a_edge;
	bpt_edge_t   b_edge;
	bpt_edge_t   t_edge;
	bpt_mode_t   state;
	bpt_mode_t   next_state;
	logic [6:0]  mode;
	logic [6:0]  next_mode;
	logic        edge_polarity;
	logic        next_edge_polarity;
	logic [15:0] active_a_compare;
	logic [15:0] next_active_a_compare;
	logic [15:0] active_b_compare;
	logic [15:0] next_active_b_compare;
	logic [15:0] a_buffer;
	logic [15:0] next_a_buffer;
	logic [15:0] b_buffer;
	logic [15:0] next_b_buffer;
	logic [15:0] alt_trigger_compare;
	logic [15:0] next_alt_trigger_compare;
	logic        out_ff;
	logic        next_out_ff;
	logic        flag;
	logic        next_flag;
	logic        b_seen;
	logic        next_b_seen;
	logic [15:0] bus_prev;
	logic [15:0] next_bus_prev;
	logic        boundary;
	logic        a_zero;
	logic        a_event;
	logic        b_event;
	logic        set_flag;

	function automatic bpt_mode_t decode_mode(input logic [6:0] m);
		if ((m & MODE_BUF_MASK) == MODE_BUF_CODE) begin
			decode_mode = BPT_BUF;
		end else if (m == MODE_SHIFT) begin
			decode_mode = BPT_SHIFT;
		end else begin
			decode_mode = BPT_IDLE;
		end
	endfunction

	// ----------------------------------------------------------------
	// register access and comparators
	// ----------------------------------------------------------------
	bpt_regs u_regs (
		.i_ref_clk   (i_ref_clk),
		.i_rst_b     (i_rst_b),
		.i_reg_wr    (i_reg_wr),
		.i_reg_rd    (i_reg_rd),
		.i_reg_addr  (i_reg_addr),
		.i_reg_wdata (i_reg_wdata),
		.i_rd_a      (state == BPT_SHIFT ? active_a_compare : a_buffer),
		.i_rd_b      (active_b_compare),
		.i_rd_alt    (alt_trigger_compare),
		.i_rd_ctrl   ({2'b00, edge_polarity, mode}),
		.i_rd_flag   (flag),
		.o_wr        (wr),
		.o_reg_rdata (o_reg_rdata)
	);

	bpt_match #(.W(CNT_W)) u_match_a (
		.i_ref_clk     (i_ref_clk),
		.i_rst_b       (i_rst_b),
		.i_count_en    (i_count_en),
		.i_counter_bus (i_counter_bus),
		.i_value       (active_a_compare),
		.o_edge        (a_edge)
	);

	bpt_match #(.W(CNT_W)) u_match_b (
		.i_ref_clk     (i_ref_clk),
		.i_rst_b       (i_rst_b),
		.i_count_en    (i_count_en),
		.i_counter_bus (i_counter_bus),
		.i_value       (active_b_compare),
		.o_edge        (b_edge)
	);

	bpt_match #(.W(CNT_W)) u_match_t (
		.i_ref_clk     (i_ref_clk),
		.i_rst_b       (i_rst_b),
		.i_count_en    (i_count_en),
		.i_counter_bus (i_counter_bus),
		.i_value       (alt_trigger_compare),
		.o_edge        (t_edge)
	);

	// ----------------------------------------------------------------
	// match qualification
	// ----------------------------------------------------------------
	always_comb begin
		// cycle boundary when the up-counting bus rolls over to one
		boundary = i_count_en && (bus_prev >= BOUNDARY_PRE)
			&& (i_counter_bus == BOUNDARY_NOW);
		a_zero = (active_a_compare == ZERO_VALUE);
		if (state == BPT_BUF) begin
			a_event = a_zero ? a_edge.rise : a_edge.fall;
			b_event = b_edge.fall;
			if (b_seen && !boundary && !a_zero) begin
				a_event = 1'b0;
			end
		end else if (state == BPT_SHIFT) begin
			a_event = a_edge.rise;
			b_event = b_edge.rise;
		end else begin
			a_event = 1'b0;
			b_event = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// configuration and compare registers
	// ----------------------------------------------------------------
	always_comb begin
		next_mode = mode;
		next_edge_polarity = edge_polarity;
		next_a_buffer = a_buffer;
		next_b_buffer = b_buffer;
		next_active_a_compare = active_a_compare;
		next_active_b_compare = active_b_compare;
		next_alt_trigger_compare = alt_trigger_compare;
		next_bus_prev = i_count_en ? i_counter_bus : bus_prev;
		if (wr.wr_ctrl) begin
			next_mode = wr.data[CTL_MODE_LSB +: MODE_W];
			next_edge_polarity = wr.data[CTL_EDGE_POLARITY_BIT];
		end
		if (wr.wr_alt) begin
			next_alt_trigger_compare = wr.data;
		end
		if (wr.wr_a) begin
			next_a_buffer = wr.data;
		end
		if (wr.wr_b) begin
			next_b_buffer = wr.data;
		end
		if (state == BPT_BUF) begin
			if (boundary && !i_output_update_disable_bit) begin
				next_active_a_compare = a_buffer;
				next_active_b_compare = b_buffer;
			end
		end else if (state == BPT_SHIFT) begin
			if (wr.wr_a) begin
				next_active_a_compare = wr.data;
			end
			if ((a_event || wr.force_a_match)
				&& !i_output_update_disable_bit) begin
				next_active_b_compare = b_buffer;
			end
		end else begin
			// outside the modes the actives follow the written values
			if (wr.wr_a) begin
				next_active_a_compare = wr.data;
			end
			if (wr.wr_b) begin
				next_active_b_compare = wr.data;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			mode <= MODE_RESET;
			edge_polarity <= 1'b0;
			a_buffer <= CMP_RESET;
			b_buffer <= CMP_RESET;
			active_a_compare <= CMP_RESET;
			active_b_compare <= CMP_RESET;
			alt_trigger_compare <= CMP_RESET;
			bus_prev <= CMP_RESET;
		end else begin
			mode <= next_mode;
			edge_polarity <= next_edge_polarity;
			a_buffer <= next_a_buffer;
			b_buffer <= next_b_buffer;
			active_a_compare <= next_active_a_compare;
			active_b_compare <= next_active_b_compare;
			alt_trigger_compare <= next_alt_trigger_compare;
			bus_prev <= next_bus_prev;
		end
	end

	// ----------------------------------------------------------------
	// mode state, output flip-flop and flag
	// ----------------------------------------------------------------
	always_comb begin
		next_state = decode_mode(mode);
		next_out_ff = out_ff;
		next_b_seen = b_seen;
		set_flag = 1'b0;
		case (state)
			BPT_BUF: begin
				if (boundary) begin
					next_b_seen = 1'b0;
				end
				if (b_event && !(a_event && a_zero)) begin
					next_out_ff = ~edge_polarity;
					next_b_seen = 1'b1;
				end else if (a_event) begin
					next_out_ff = edge_polarity;
				end
				set_flag = b_event
					|| (mode[MODE_FLAG_SEL] && a_event);
				if (wr.force_b_match) begin
					next_out_ff = ~edge_polarity;
				end else if (wr.force_a_match) begin
					next_out_ff = edge_polarity;
				end
			end
			BPT_SHIFT: begin
				if (b_event) begin
					next_out_ff = ~edge_polarity;
				end else if (a_event) begin
					next_out_ff = edge_polarity;
				end
				set_flag = t_edge.rise;
				if (wr.force_b_match) begin
					next_out_ff = ~edge_polarity;
				end else if (wr.force_a_match) begin
					next_out_ff = edge_polarity;
				end
			end
			default: begin
				next_b_seen = 1'b0;
			end
		endcase
		if (next_state != state) begin
			next_b_seen = 1'b0;
			if (next_state == BPT_BUF) begin
				next_out_ff = next_edge_polarity;
			end else if (next_state == BPT_SHIFT) begin
				next_out_ff = ~next_edge_polarity;
			end
		end
		// a set in the clearing cycle wins
		next_flag = set_flag | (flag & ~wr.clr_flag);
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			state <= BPT_IDLE;
			out_ff <= 1'b0;
			flag <= 1'b0;
			b_seen <= 1'b0;
		end else begin
			state <= next_state;
			out_ff <= next_out_ff;
			flag <= next_flag;
			b_seen <= next_b_seen;
		end
	end

	assign o_pwm = out_ff;
	assign o_flag = flag;
	assign o_mode_state = state;
endmodule
`default_nettype wire

/* File: bpt_checker.sv */
`default_nettype none
module bpt_checker
	import bpt_pkg::*;
(
	input wire logic        i_ref_clk,
	input wire logic        i_rst_b,
	input wire logic        i_reg_wr,
	input wire logic        i_reg_rd,
	input wire logic [4:0]  i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic [31:0] o_reg_rdata,
	input wire logic [15:0] i_counter_bus,
	input wire logic        i_count_en,
	input wire logic        i_output_update_disable_bit,
	input wire logic        o_pwm,
	input wire logic        o_flag,
	input wire logic [1:0]  o_mode_state
);
	// ----
	// polarity shadow and checks
	// ----
	logic pol_q;
	always_ff @(posedge i_ref_clk)
		if (!i_rst_b)
			pol_q <= 1'b0;
		else if (i_reg_wr && i_reg_addr == OFS_CONTROL)
			pol_q <= i_reg_wdata[CTL_EDGE_POLARITY_BIT];
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	chk_reset_idle: assert property ($rose(i_rst_b) |-> !o_pwm && !o_flag
		&& o_mode_state == 2'h0 && o_reg_rdata == 32'h0)
		else $error("outputs not idle after reset");
	chk_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
		else $error("read data moved without a read");
	chk_unmapped_zero: assert property (i_reg_rd && i_reg_addr == 5'h08
		|=> o_reg_rdata == 32'h0) else $error("unmapped read not zero");
	chk_upper_zero: assert property (i_reg_rd
		|=> o_reg_rdata[31:16] == 16'h0) else $error("upper bits not zero");
	chk_flag_cause:
		assert property ($rose(o_flag) |-> $past(i_count_en)
		|| $past(i_count_en, 2)) else $error("flag set without a count");
	chk_pwm_cause:
		assert property ($changed(o_pwm) |-> $past(i_count_en)
		|| $past(i_count_en, 2) || $past(i_reg_wr) || $past(i_reg_wr, 2)
		|| $past(i_reg_wr, 3) || $past(i_reg_wr, 4))
		else $error("pwm moved without a cause");
	chk_buf_entry:
		assert property ($changed(o_mode_state) && o_mode_state == 2'h1
		|-> ##[0:2] o_pwm == pol_q) else $error("buffered entry level");
	chk_shift_entry:
		assert property ($changed(o_mode_state) && o_mode_state == 2'h2
		|-> ##[0:2] o_pwm == !pol_q) else $error("shifted entry level");
	chk_flag_clear: assert property ((i_reg_wr && i_reg_addr == OFS_STATUS
		&& i_reg_wdata[STS_FLAG_BIT] && !i_count_en) ##1 !i_count_en [*2]
		|-> !o_flag) else $error("flag not cleared");
endmodule
bind bpt_channel bpt_checker i_bpt_checker (.i_ref_clk, .i_rst_b, .i_reg_wr,
	.i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_counter_bus,
	.i_count_en, .i_output_update_disable_bit, .o_pwm, .o_flag,
	.o_mode_state);
`default_nettype wire

/* File: bpt_bus_model.sv */
`default_nettype none
module bpt_bus_model
	import bpt_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_b,
	input  wire logic        i_run,
	input  wire logic        i_slow,
	input  wire logic [15:0] i_max,
	output logic [15:0]      o_counter_bus,
	output logic             o_count_en
);
	// ----
	// modulus up counter, restarts at one when stopped
	// ----
	logic ph;
	always_ff @(posedge i_ref_clk)
		if (!i_rst_b || !i_run) begin
			o_count_en <= 1'b0;
			o_counter_bus <= 16'h0001;
			ph <= 1'b0;
		end else begin
			ph <= !ph;
			o_count_en <= !i_slow || ph;
			if (!i_slow || ph)
				o_counter_bus <= (o_counter_bus >= i_max) ? 16'h0001
					: o_counter_bus + 16'h0001;
		end
endmodule
`default_nettype wire

/* File: bpt_channel_bench.sv */
`default_nettype none
module bpt_channel_bench
	import bpt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [1:0]  k;
		logic [31:0] v;
	} bpt_exp_t;
	logic        ref_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        rd_d = 1'b0;
	logic        smp = 1'b0;
	logic        ud = 1'b0;
	logic        run = 1'b0;
	logic        slow = 1'b0;
	logic [4:0]  addr = 5'h00;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdata;
	logic        pwm;
	logic        flag;
	logic [15:0] bus;
	logic        cen;
	logic [15:0] a;
	logic [15:0] b;
	bpt_exp_t    e;
	bpt_exp_t    expq[$];
	int          error_cnt = 0;
	int          compares = 0;
	always #4 ref_clk = ~ref_clk;
	bpt_channel i_bpt_channel (.i_ref_clk(ref_clk), .i_rst_b(rst_b),
		.i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd),
		.o_reg_rdata(rdata), .i_counter_bus(bus), .i_count_en(cen),
		.i_output_update_disable_bit(ud), .o_pwm(pwm), .o_flag(flag),
		.o_mode_state());
	bpt_bus_model i_bpt_bus_model (.i_ref_clk(ref_clk), .i_rst_b(rst_b),
		.i_run(run), .i_slow(slow), .i_max(16'h0014), .o_counter_bus(bus),
		.o_count_en(cen));
	// ----
	// checking
	// ----
	task automatic cmp_rd(input string n, input logic [31:0] x,
		input logic [31:0] g);
		compares++;
		if (g !== x) begin
			error_cnt++;
			$display("ERROR %s exp %h got %h", n, x, g);
		end
	endtask
	task automatic cmp_bit(input string n, input logic x, input logic g);
		compares++;
		if (g !== x) begin
			error_cnt++;
			$display("ERROR %s exp %b got %b", n, x, g);
		end
	endtask
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		rd_d <= rd;
		if (rd_d || smp) begin
			e = expq.pop_front();
			if (e.k == 2'h0)
				cmp_rd("rdata", e.v, rdata);
			else if (e.k == 2'h1)
				cmp_bit("pwm", e.v[0], pwm);
			else
				cmp_bit("flag", e.v[0], flag);
		end
	end
	// ----
	// drivers
	// ----
	task automatic wr_reg(input logic [4:0] ad, input logic [31:0] d);
		@(posedge ref_clk);
		wr <= 1'b1;
		addr <= ad;
		wd <= d;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [4:0] ad, input logic [31:0] x);
		@(posedge ref_clk);
		rd <= 1'b1;
		addr <= ad;
		expq.push_back('{2'h0, x});
		@(posedge ref_clk);
		rd <= 1'b0;
	endtask
	task automatic chk(input logic [1:0] k, input logic v);
		@(posedge ref_clk);
		smp <= 1'b1;
		expq.push_back('{k, {31'h0, v}});
		@(posedge ref_clk);
		smp <= 1'b0;
	endtask
	task automatic ctl(input logic [6:0] m, input logic p, input logic fa,
		input logic fb);
		wr_reg(OFS_CONTROL, {22'h0, fb, fa, p, m});
	endtask
	task automatic go();
		@(posedge ref_clk);
		run <= 1'b1;
		slow <= 1'($urandom);
	endtask
	task automatic stop();
		@(posedge ref_clk);
		run <= 1'b0;
	endtask
	task automatic wait_bus(input logic [15:0] v);
		int n = 0;
		do begin
			@(posedge ref_clk);
			n++;
			if (n > 400) begin
				error_cnt++;
				give_verdict();
			end
		end while (!(cen === 1'b1 && bus === v));
	endtask
	task automatic enter(input logic [6:0] m, input logic p,
		input logic [15:0] av, input logic [15:0] bv);
		stop();
		ctl(MODE_RESET, p, 1'b0, 1'b0);
		wr_reg(OFS_COMPARE_A, {16'h0, av});
		wr_reg(OFS_COMPARE_B, {16'h0, bv});
		wr_reg(OFS_STATUS, 32'h1);
		ctl(m, p, 1'b0, 1'b0);
		repeat (4) @(posedge ref_clk);
	endtask
	initial begin
		void'($urandom(73346));
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
		a = 16'($urandom_range(2, 4));
		b = 16'($urandom_range(9, 11));
		rd_reg(OFS_COMPARE_A, 32'h0);
		rd_reg(5'h08, 32'h0);
		wr_reg(OFS_ALT_TRIG, {16'h0, b});
		rd_reg(OFS_ALT_TRIG, {16'h0, b});
		$display("test registers done");
		wr_reg(OFS_ALT_TRIG, 32'h12);
		enter(MODE_SHIFT, 1'b1, a, b);
		chk(2'h1, 1'b0);
		go();
		wait_bus(a + 16'h1);
		chk(2'h1, 1'b1);
		wait_bus(b + 16'h1);
		chk(2'h1, 1'b0);
		chk(2'h2, 1'b0);
		wait_bus(16'h13);
		chk(2'h2, 1'b1);
		wait_bus(a + 16'h1);
		chk(2'h1, 1'b1);
		stop();
		wr_reg(OFS_COMPARE_B, {16'h0, b + 16'h1});
		rd_reg(OFS_COMPARE_B, {16'h0, b});
		go();
		wait_bus(a + 16'h1);
		stop();
		rd_reg(OFS_COMPARE_B, {16'h0, b + 16'h1});
		ud <= 1'b1;
		wr_reg(OFS_COMPARE_B, {16'h0, b});
		wr_reg(OFS_COMPARE_A, 32'h5);
		rd_reg(OFS_COMPARE_A, 32'h5);
		go();
		wait_bus(16'h6);
		stop();
		rd_reg(OFS_COMPARE_B, {16'h0, b + 16'h1});
		ud <= 1'b0;
		wr_reg(OFS_COMPARE_B, {16'h0, b});
		for (int i = 0; i < 4; i++) begin
			ctl(MODE_SHIFT, 1'b1, !i[0] || i[1], i[0]);
			chk(2'h1, !i[0]);
		end
		rd_reg(OFS_COMPARE_B, {16'h0, b});
		wr_reg(OFS_COMPARE_B, 32'h5);
		ctl(MODE_SHIFT, 1'b1, 1'b1, 1'b0);
		go();
		wait_bus(16'h9);
		chk(2'h1, 1'b0);
		$display("test shifted done");
		for (int i = 0; i < 2; i++) begin
			enter(MODE_BUF_CODE | 7'(i << 1), i[0], 16'h4, 16'hB);
			chk(2'h1, i[0]);
			ctl(MODE_BUF_CODE | 7'(i << 1), i[0], 1'b0, 1'b1);
			chk(2'h1, !i[0]);
			chk(2'h2, 1'b0);
			go();
			wait_bus(16'h7);
			chk(2'h1, i[0]);
			chk(2'h2, i[0]);
			wr_reg(OFS_COMPARE_A, 32'h6);
			wait_bus(16'hD);
			chk(2'h1, !i[0]);
			chk(2'h2, 1'b1);
			wait_bus(16'h5);
			chk(2'h1, !i[0]);
			wait_bus(16'h8);
			chk(2'h1, i[0]);
		end
		$display("test buffered done");
		give_verdict();
	end
endmodule
`default_nettype wire
